// ==== scdd_pkg.sv ====
// scdd_pkg: constants and types for the sample clock delay and detect block
// assumes: one 20 MHz clock, byte-wide register port, 12-bit addresses
`default_nettype none
package scdd_pkg;
  // -------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------
  localparam logic [11:0] ADDR_DLY_MODE = 12'h0110;
  localparam logic [11:0] ADDR_A_SFINE = 12'h0111;
  localparam logic [11:0] ADDR_A_FINE = 12'h0112;
  localparam logic [11:0] ADDR_D_SFINE = 12'h0113;
  localparam logic [11:0] ADDR_D_FINE = 12'h0114;
  localparam logic [11:0] ADDR_DET_THR = 12'h011A;
  localparam logic [11:0] ADDR_CLK_STAT = 12'h011B;
  localparam logic [11:0] ADDR_PHASE_STAT = 12'h0109;
  localparam logic [11:0] ADDR_REF_CTRL = 12'h010A;
  localparam logic [11:0] ADDR_PHASE_OFS = 12'h0129;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h0130;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h0131;
  // -------------------------------------------------------------------
  // reset values and field positions
  // -------------------------------------------------------------------
  localparam logic [7:0] RST_FINE = 8'hC0;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [1:0] RST_THR = 2'h1;
  localparam logic [2:0] RST_THR_LOW = 3'h6;
  localparam logic [7:0] FINE_MAX = 8'hC0;
  localparam logic [7:0] FINE_MAX_RESTR = 8'h10;
  localparam int REF_EN_BIT = 7;
  localparam int IRQ_LOSS_BIT = 0;
  localparam int IRQ_GAIN_BIT = 1;
  localparam int IRQ_CAP_BIT = 2;
  // -------------------------------------------------------------------
  // delay modes
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    DM_NONE = 3'b000,
    DM_FINE_RESTR = 3'b010,
    DM_FINE_LOWJIT = 3'b011,
    DM_FINE_FULL = 3'b100,
    DM_FINE_SUPER = 3'b110
  } scdd_mode_e;
  // applied delay carried to the analog path
  typedef struct packed {
    logic fine_en;
    logic super_en;
    logic [7:0] fine;
    logic [7:0] sfine;
  } scdd_delay_s;
endpackage : scdd_pkg
`default_nettype wire

// ==== scdd_tb.sv ====
// scdd_tb: self-checking bench for the sample clock delay and detect block
// assumes: scdd_pkg and scdd_top are compiled first; one 20 MHz clock
`default_nettype none
module tb
  import scdd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------------
  // signals and design instance
  // ---------------------------------------------------------------------
  logic i_mclk, i_rst_n, i_wr, i_rd, i_clk_present, i_cap_valid;
  logic [11:0] i_addr;
  logic [7:0] i_wdata, o_rdata, got;
  logic [3:0] i_cap_phase;
  logic [1:0] o_det_thr;
  logic o_irq;
  scdd_delay_s o_adc_dly, o_dig_dly;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [11:0] rst_addr [10] = '{ADDR_DLY_MODE, ADDR_A_SFINE, ADDR_A_FINE,
    ADDR_D_SFINE, ADDR_D_FINE, ADDR_DET_THR, ADDR_CLK_STAT, ADDR_PHASE_STAT,
    ADDR_IRQ_STAT, ADDR_IRQ_MASK};
  logic [7:0] rst_val [10] = '{8'h00, 8'h00, 8'hC0, 8'h00, 8'hC0, 8'h0E,
    8'h00, 8'h00, 8'h00, 8'h00};
  scdd_top dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_clk_present(i_clk_present), .i_cap_phase(i_cap_phase),
    .i_cap_valid(i_cap_valid), .o_adc_dly(o_adc_dly),
    .o_dig_dly(o_dig_dly), .o_det_thr(o_det_thr), .o_irq(o_irq));
  // clock: 50 ns period
  initial i_mclk = 1'b0;
  always #25 i_mclk = ~i_mclk;
  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [17:0] g, input logic [17:0] e,
                     input string what);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  // read strobe, data taken in the following cycle only
  task automatic rd_get(input logic [11:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd_get
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_get(a, d);
    chk({10'h000, d}, {10'h000, e}, "read");
  endtask : rd
  // bounded poll of the clock status bit
  task automatic wait_stat(input logic [7:0] e);
    for (int k = 0; k < 20; k++) begin
      rd_get(ADDR_CLK_STAT, got);
      if (got === e) return;
    end
    n_mismatch++;
    $display("[ERR] %0t clock status never reached %h", $time, e);
    stop_test();
  endtask : wait_stat
  // expected applied delay for a mode and trim pair
  function automatic scdd_delay_s exp_dly(input int m, input logic [7:0] f,
                                          input logic [7:0] s);
    scdd_delay_s r;
    r.fine_en = (m == 2) || (m == 3) || (m == 4) || (m == 6);
    r.super_en = (m == 2) || (m == 6);
    r.fine = r.fine_en ? ((f > FINE_MAX) ? FINE_MAX : f) : 8'h00;
    r.sfine = r.super_en ? s : 8'h00;
    return r;
  endfunction : exp_dly
  // ---------------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------------
  initial begin
    #2000000;
    n_mismatch++;
    $display("[ERR] %0t run did not finish", $time);
    stop_test();
  end
  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 12'h000;
    i_wdata = 8'h00;
    i_clk_present = 1'b0;
    i_cap_phase = 4'h0;
    i_cap_valid = 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    // reset values of ten registers, all but ADDR_REF_CTRL and ADDR_PHASE_OFS
    for (int i = 0; i < 10; i++) rd(rst_addr[i], rst_val[i]);
    chk({16'h0000, o_det_thr}, 18'h0_0001, "thr reset");
    // unmapped and read-only places keep their value
    wr(12'h0115, 8'hAA);
    rd(12'h0115, 8'h00);
    wr(ADDR_CLK_STAT, 8'hFF);
    rd(ADDR_CLK_STAT, 8'h00);
    // fine trims kept within 0..16 so modes 010/011 stay legal
    wr(ADDR_A_SFINE, 8'h55);
    wr(ADDR_A_FINE, 8'h10);
    wr(ADDR_D_SFINE, 8'h33);
    wr(ADDR_D_FINE, 8'h0C);
    // every mode code, including the undefined ones
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_DLY_MODE, {5'h00, m[2:0]});
      repeat (2) @(posedge i_mclk);
      #1 chk(o_adc_dly, exp_dly(m, 8'h10, 8'h55), "adc dly");
      chk(o_dig_dly, exp_dly(m, 8'h0C, 8'h33), "dig dly");
      rd(ADDR_DLY_MODE, {5'h00, m[2:0]});
    end
    // full range in mode 100, top step and one past it
    wr(ADDR_DLY_MODE, 8'h04);
    wr(ADDR_A_FINE, 8'hC0);
    wr(ADDR_D_FINE, 8'hC1);
    repeat (2) @(posedge i_mclk);
    #1 chk(o_adc_dly, exp_dly(4, 8'hC0, 8'h55), "adc full");
    chk(o_dig_dly, exp_dly(4, 8'hC1, 8'h33), "dig clamp");
    rd(ADDR_D_FINE, 8'hC1);
    // low sample rate threshold
    wr(ADDR_DET_THR, 8'h16);
    rd(ADDR_DET_THR, 8'h16);
    chk({16'h0000, o_det_thr}, 18'h0_0002, "thr");
    // clock gained: unmasked event raises the interrupt
    wr(ADDR_IRQ_MASK, 8'h02);
    i_clk_present <= 1'b1;
    wait_stat(8'h01);
    repeat (2) @(posedge i_mclk);
    #1 chk({17'h0_0000, o_irq}, 18'h0_0001, "irq gain");
    rd(ADDR_IRQ_STAT, 8'h02);
    wr(ADDR_IRQ_STAT, 8'h02);
    #1 chk({17'h0_0000, o_irq}, 18'h0_0000, "irq clear");
    // clock lost: event recorded but masked
    i_clk_present <= 1'b0;
    wait_stat(8'h00);
    repeat (2) @(posedge i_mclk);
    rd(ADDR_IRQ_STAT, 8'h01);
    #1 chk({17'h0_0000, o_irq}, 18'h0_0000, "irq masked");
    // phase readback follows the offset with zero skew windows
    wr(ADDR_REF_CTRL, 8'h80);
    wr(ADDR_PHASE_OFS, 8'hFB);
    repeat (2) @(posedge i_mclk);
    rd(ADDR_PHASE_STAT, 8'h0B);
    // skew window set: captured phase is reported instead
    wr(ADDR_REF_CTRL, 8'h85);
    @(posedge i_mclk);
    i_cap_phase <= 4'h5;
    i_cap_valid <= 1'b1;
    @(posedge i_mclk);
    i_cap_valid <= 1'b0;
    repeat (2) @(posedge i_mclk);
    rd(ADDR_PHASE_STAT, 8'h05);
    rd(ADDR_IRQ_STAT, 8'h05);
    stop_test();
  end
endmodule : tb
`default_nettype wire

// ==== scdd_top.sv ====
// scdd_top: delay mode, trim registers, clock detect status, phase readback
// assumes: i_clk_present is an asynchronous level from the analog detector,
// i_cap_phase/i_cap_valid arrive from the divider logic on i_mclk
//
// Function
// - read-only four-bit field reports captured divider phase in half cycles
// - with adjust on and zero skew windows, readback equals phase offset
// - mode 000 no delay; 010,011,100,110 fine delay; 100 allows 192
// - mode 110 enables fine (192 steps) and super-fine (255 steps)
// - analog super-fine eight-bit count applies only in modes 010, 110
// - analog fine count 0..192, resets 0xC0, applies in 2,3,4,6
// - digital super-fine eight-bit count, modes 010/110 only, resets zero
// - digital fine count 0..192, resets 0xC0, honoured in 2,3,4,6
`default_nettype none
module scdd_top
  import scdd_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // register port
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // analog side
  input wire logic i_clk_present,
  input wire logic [3:0] i_cap_phase,
  input wire logic i_cap_valid,
  output scdd_delay_s o_adc_dly,
  output scdd_delay_s o_dig_dly,
  output logic [1:0] o_det_thr,
  // interrupt
  output logic o_irq
);
  // -------------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------------
  logic [2:0] mode_reg;
  logic [7:0] a_sfine_reg, a_fine_reg, d_sfine_reg, d_fine_reg;
  logic [1:0] thr_reg;
  logic [2:0] thr_low_reg;
  logic [2:0] thr_top_reg;
  logic [7:0] ref_ctrl_reg;
  logic [3:0] phase_ofs_reg;
  logic [3:0] phase_reg;
  logic [2:0] irq_stat_reg, irq_mask_reg;
  logic det_s1_reg, det_s2_reg, det_reg;
  logic wr_stat;

  // software-written fields
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_reg <= DM_NONE;
      a_sfine_reg <= RST_ZERO;
      a_fine_reg <= RST_FINE;
      d_sfine_reg <= RST_ZERO;
      d_fine_reg <= RST_FINE;
      thr_reg <= RST_THR;
      thr_low_reg <= RST_THR_LOW;
      thr_top_reg <= '0;
      ref_ctrl_reg <= RST_ZERO;
      phase_ofs_reg <= '0;
      irq_mask_reg <= '0;
    end else if (i_wr) begin
      case (i_addr)
        ADDR_DLY_MODE: mode_reg <= i_wdata[2:0];
        ADDR_A_SFINE: a_sfine_reg <= i_wdata;
        ADDR_A_FINE: a_fine_reg <= i_wdata;
        ADDR_D_SFINE: d_sfine_reg <= i_wdata;
        ADDR_D_FINE: d_fine_reg <= i_wdata;
        ADDR_DET_THR: begin
          thr_top_reg <= i_wdata[7:5];
          thr_reg <= i_wdata[4:3];
          thr_low_reg <= i_wdata[2:0];
        end
        ADDR_REF_CTRL: ref_ctrl_reg <= i_wdata;
        ADDR_PHASE_OFS: phase_ofs_reg <= i_wdata[3:0];
        ADDR_IRQ_MASK: irq_mask_reg <= i_wdata[2:0];
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // delay application per mode
  // -------------------------------------------------------------------
  logic fine_on, super_on;
  always_comb begin
    case (scdd_mode_e'(mode_reg))
      DM_FINE_RESTR: begin
        fine_on = 1'b1;
        super_on = 1'b1;
      end
      DM_FINE_LOWJIT: begin
        fine_on = 1'b1;
        super_on = 1'b0;
      end
      DM_FINE_FULL: begin
        fine_on = 1'b1;
        super_on = 1'b0;
      end
      DM_FINE_SUPER: begin
        fine_on = 1'b1;
        super_on = 1'b1;
      end
      default: begin
        fine_on = 1'b0;
        super_on = 1'b0;
      end
    endcase
  end

  // clamp a fine count to the documented top step
  function automatic logic [7:0] fine_clamp(input logic [7:0] v);
    fine_clamp = (v > FINE_MAX) ? FINE_MAX : v;
  endfunction : fine_clamp

  // the restricted top step must sit inside the full range the clamp serves
  if (FINE_MAX_RESTR > FINE_MAX) begin : g_bad_steps
    $error("restricted top step above full top step");
  end

  // registered delay outputs; disabled fields read zero downstream
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_adc_dly <= '0;
      o_dig_dly <= '0;
    end else begin
      o_adc_dly.fine_en <= fine_on;
      o_adc_dly.super_en <= super_on;
      o_adc_dly.fine <= fine_on ? fine_clamp(a_fine_reg) : RST_ZERO;
      o_adc_dly.sfine <= super_on ? a_sfine_reg : RST_ZERO;
      o_dig_dly.fine_en <= fine_on;
      o_dig_dly.super_en <= super_on;
      o_dig_dly.fine <= fine_on ? fine_clamp(d_fine_reg) : RST_ZERO;
      o_dig_dly.sfine <= super_on ? d_sfine_reg : RST_ZERO;
    end
  end

  assign o_det_thr = thr_reg;

  // -------------------------------------------------------------------
  // clock detect synchroniser and status
  // -------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      det_s1_reg <= 1'b0;
      det_s2_reg <= 1'b0;
      det_reg <= 1'b0;
    end else begin
      det_s1_reg <= i_clk_present;
      det_s2_reg <= det_s1_reg;
      det_reg <= det_s2_reg;
    end
  end

  // -------------------------------------------------------------------
  // captured phase readback
  // -------------------------------------------------------------------
  logic ref_en, skew_zero;
  assign ref_en = ref_ctrl_reg[REF_EN_BIT];
  assign skew_zero = (ref_ctrl_reg[3:0] == 4'h0);
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_reg <= '0;
    end else if (ref_en && skew_zero) begin
      phase_reg <= phase_ofs_reg;
    end else if (ref_en && i_cap_valid) begin
      phase_reg <= i_cap_phase;
    end
  end

  // -------------------------------------------------------------------
  // interrupt status: set wins over write-one-to-clear
  // -------------------------------------------------------------------
  logic [2:0] irq_ev;
  assign irq_ev[IRQ_LOSS_BIT] = det_reg & ~det_s2_reg;
  assign irq_ev[IRQ_GAIN_BIT] = ~det_reg & det_s2_reg;
  assign irq_ev[IRQ_CAP_BIT] = ref_en & i_cap_valid;
  assign wr_stat = i_wr && (i_addr == ADDR_IRQ_STAT);
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? i_wdata[2:0] : 3'h0))
        | irq_ev;
    end
  end
  assign o_irq = |(irq_stat_reg & irq_mask_reg);

  // -------------------------------------------------------------------
  // read data, one cycle after the strobe
  // -------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= RST_ZERO;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_DLY_MODE: o_rdata <= {5'h00, mode_reg};
        ADDR_A_SFINE: o_rdata <= a_sfine_reg;
        ADDR_A_FINE: o_rdata <= a_fine_reg;
        ADDR_D_SFINE: o_rdata <= d_sfine_reg;
        ADDR_D_FINE: o_rdata <= d_fine_reg;
        ADDR_DET_THR: o_rdata <= {thr_top_reg, thr_reg, thr_low_reg};
        ADDR_CLK_STAT: o_rdata <= {7'h00, det_reg};
        ADDR_PHASE_STAT: o_rdata <= {4'h0, phase_reg};
        ADDR_REF_CTRL: o_rdata <= ref_ctrl_reg;
        ADDR_PHASE_OFS: o_rdata <= {4'h0, phase_ofs_reg};
        ADDR_IRQ_STAT: o_rdata <= {5'h00, irq_stat_reg};
        ADDR_IRQ_MASK: o_rdata <= {5'h00, irq_mask_reg};
        default: o_rdata <= RST_ZERO;
      endcase
    end else begin
      o_rdata <= RST_ZERO;
    end
  end

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_phase_ofs;
    ref_en && skew_zero |=> phase_reg == $past(phase_ofs_reg);
  endproperty
  a_phase_ofs: assert property (p_phase_ofs)
    else $error("phase readback differs from offset");

  property p_phase_cap;
    ref_en && !skew_zero && i_cap_valid |=> phase_reg == $past(i_cap_phase);
  endproperty
  a_phase_cap: assert property (p_phase_cap)
    else $error("captured phase not reported");

  property p_no_delay;
    mode_reg == DM_NONE |=> !o_adc_dly.fine_en && o_adc_dly.fine == 8'h00;
  endproperty
  a_no_delay: assert property (p_no_delay)
    else $error("delay applied in mode none");

  property p_super_mode;
    mode_reg == DM_FINE_SUPER |=> o_adc_dly.super_en && o_dig_dly.fine_en;
  endproperty
  a_super_mode: assert property (p_super_mode)
    else $error("mode 110 did not enable both delays");

  property p_asfine;
    mode_reg != DM_FINE_RESTR && mode_reg != DM_FINE_SUPER
      |=> o_adc_dly.sfine == 8'h00;
  endproperty
  a_asfine: assert property (p_asfine)
    else $error("analog super-fine outside its modes");

  property p_afine;
    o_adc_dly.fine <= FINE_MAX;
  endproperty
  a_afine: assert property (p_afine)
    else $error("analog fine above top step");

  property p_dsfine;
    mode_reg == DM_FINE_SUPER |=> o_dig_dly.sfine == $past(d_sfine_reg);
  endproperty
  a_dsfine: assert property (p_dsfine)
    else $error("digital super-fine not applied");

  property p_dfine;
    mode_reg == DM_FINE_FULL && d_fine_reg <= FINE_MAX
      |=> o_dig_dly.fine == $past(d_fine_reg);
  endproperty
  a_dfine: assert property (p_dfine)
    else $error("digital fine not applied");

  property p_det;
    $rose(det_s2_reg) |=> det_reg && irq_stat_reg[IRQ_GAIN_BIT];
  endproperty
  a_det: assert property (p_det)
    else $error("clock status not following detector");

  // every fine mode turns the fine delay on for both clocks
  property p_fine_modes;
    mode_reg == DM_FINE_RESTR || mode_reg == DM_FINE_LOWJIT
      || mode_reg == DM_FINE_FULL || mode_reg == DM_FINE_SUPER
      |=> o_adc_dly.fine_en && o_dig_dly.fine_en;
  endproperty
  a_fine_modes: assert property (p_fine_modes)
    else $error("fine delay off in a fine mode");

  // an in-range analog fine count passes through unchanged in mode 100
  property p_afine_apply;
    mode_reg == DM_FINE_FULL && a_fine_reg <= FINE_MAX
      |=> o_adc_dly.fine == $past(a_fine_reg);
  endproperty
  a_afine_apply: assert property (p_afine_apply)
    else $error("analog fine not applied");

  // digital super-fine stays off outside modes 010 and 110
  property p_dsfine_off;
    mode_reg != DM_FINE_RESTR && mode_reg != DM_FINE_SUPER
      |=> o_dig_dly.sfine == 8'h00 && !o_dig_dly.super_en;
  endproperty
  a_dsfine_off: assert property (p_dsfine_off)
    else $error("digital super-fine outside its modes");

  // mode 010 carries the analog super-fine count
  property p_asfine_apply;
    mode_reg == DM_FINE_RESTR |=> o_adc_dly.sfine == $past(a_sfine_reg);
  endproperty
  a_asfine_apply: assert property (p_asfine_apply)
    else $error("analog super-fine not applied in mode 010");

  // no digital fine delay with the delay switched off
  property p_dfine_off;
    mode_reg == DM_NONE |=> !o_dig_dly.fine_en && o_dig_dly.fine == 8'h00;
  endproperty
  a_dfine_off: assert property (p_dfine_off)
    else $error("digital fine applied in mode none");

  // readback only moves while the reference adjust is enabled
  property p_phase_hold;
    !ref_en |=> $stable(phase_reg);
  endproperty
  a_phase_hold: assert property (p_phase_hold)
    else $error("phase readback moved with adjust off");

  // a detected clock reads back as a one in the status register
  property p_stat_rd;
    i_rd && i_addr == ADDR_CLK_STAT && det_reg |=> o_rdata == 8'h01;
  endproperty
  a_stat_rd: assert property (p_stat_rd)
    else $error("clock status read wrong");

  // a gain event is recorded even when a clear write lands with it
  property p_gain_set;
    irq_ev[IRQ_GAIN_BIT] |=> irq_stat_reg[IRQ_GAIN_BIT];
  endproperty
  a_gain_set: assert property (p_gain_set)
    else $error("gain event lost");

  // read data rests at zero outside the cycle after a read strobe
  property p_rd_idle;
    !i_rd |=> o_rdata == RST_ZERO;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");

  // main scenarios worth seeing
  c_super: cover property (mode_reg == DM_FINE_SUPER ##1 o_adc_dly.super_en);
  c_lock: cover property ($rose(det_reg));
  c_irq: cover property ($rose(o_irq));
  c_cap: cover property (ref_en && i_cap_valid);
  c_restr: cover property (mode_reg == DM_FINE_RESTR
    && a_fine_reg <= FINE_MAX_RESTR);
endmodule : scdd_top
`default_nettype wire
